// ==== sea_acq.sv ====
// Top of the encoder value acquisition: triggering, decoding, normalization
`timescale 1ns/1ps
module sea_acq #(
	parameter int MONOFLOP_CYCLES = sea_pkg::MONOFLOP_CYC,
	parameter int UPDATE_CYCLES = sea_pkg::UPDATE_CYC,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic iso_mode_i,
	input wire logic iso_ok_i,
	input wire logic iso_ti_i,
	input wire logic [7:0] iso_skip_i,
	input wire logic detect_i,
	input wire logic code_gray_i,
	input wire logic norm_on_i,
	input wire logic fast_mode_i,
	input wire logic [2:0] enc_type_i,
	input wire logic [sea_pkg::SHIFT_W-1:0] trail_bits_i,
	input wire logic [sea_pkg::WORD_W-1:0] total_steps_i,
	input wire logic enc_data_i,
	output logic enc_clk_o,
	output logic [sea_pkg::WORD_W-1:0] fb_value_o,
	output logic fb_strobe_o,
	input wire logic fb_ready_i,
	output logic [7:0] fb_life_o,
	output logic fb_ready_op_o,
	output logic cmp_latch_avail_o,
	output logic fifo_full_o
);
	// ----------------------------------------
	// Mode selection and triggering
	// ----------------------------------------
	logic [1:0] ti_sync_r;
	logic ti_prev_r;
	logic [sea_pkg::CNT_W-1:0] mono_r;
	logic [sea_pkg::CNT_W-1:0] upd_r;
	logic [7:0] skip_r;
	logic valid_r;
	logic [sea_pkg::WORD_W-1:0] last_r;
	logic [7:0] life_r;
	logic link_busy;
	logic link_done;
	logic [sea_pkg::WORD_W-1:0] link_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [sea_pkg::WORD_W-1:0] fifo_out_data;

	wire logic ti_rise = ti_sync_r[1] && !ti_prev_r;
	wire logic type_good = sea_pkg::type_ok(enc_type_i);
	wire logic [sea_pkg::BITS_W-1:0] nbits = sea_pkg::frame_bits(enc_type_i);
	wire logic run_iso = iso_mode_i;
	wire logic run_free = !iso_mode_i && (detect_i == sea_pkg::DET_FREE);
	wire logic run_sync = !iso_mode_i && (detect_i == sea_pkg::DET_SYNC);
	wire logic mono_end = mono_r == sea_pkg::CNT_W'(MONOFLOP_CYCLES - 1);
	wire logic upd_end = upd_r == sea_pkg::CNT_W'(UPDATE_CYCLES - 1);
	wire logic trig_free = run_free && mono_end;
	wire logic trig_sync = run_sync && upd_end;
	// iso frame at input instant, skipping by rate
	wire logic trig_iso = run_iso && iso_ok_i && ti_rise && (skip_r == 8'h00);
	wire logic frame_start = enable_i && type_good && !link_busy && (trig_free || trig_sync || trig_iso);

	// ----------------------------------------
	// Decode and normalization
	// ----------------------------------------
	// word masked to selected width
	wire logic [sea_pkg::WORD_W-1:0] width_mask = sea_pkg::WORD_W'((26'h0000001 << nbits) - 26'h0000001);
	wire logic [sea_pkg::WORD_W-1:0] raw_word = link_word & width_mask;
	logic [sea_pkg::WORD_W-1:0] gray_bin;
	always_comb begin
		gray_bin = '0;
		gray_bin[sea_pkg::WORD_W-1] = raw_word[sea_pkg::WORD_W-1];
		for (int i = sea_pkg::WORD_W - 2; i >= 0; i--) begin
			gray_bin[i] = raw_word[i] ^ gray_bin[i+1];
		end
	end
	wire logic [sea_pkg::WORD_W-1:0] decoded = (code_gray_i == sea_pkg::CODE_GRAY) ? gray_bin : raw_word;
	// field sized by total step count
	wire logic [sea_pkg::WORD_W-1:0] step_mask = (total_steps_i == '0) ? '1 : total_steps_i - sea_pkg::WORD_W'(1);
	wire logic [sea_pkg::WORD_W-1:0] shifted = decoded >> trail_bits_i;
	wire logic [sea_pkg::WORD_W-1:0] norm_word = norm_on_i ? (shifted & step_mask) : decoded;

	// ----------------------------------------
	// Sampling to feedback
	// ----------------------------------------
	// free-running samples latest per update
	wire logic sample_free = run_free && upd_end && valid_r;
	wire logic sample_sync = run_sync && link_done;
	// iso updates only while bus cycle ok
	wire logic sample_iso = run_iso && iso_ok_i && link_done;
	wire logic push_word = enable_i && (sample_free || sample_sync || sample_iso);
	wire logic [sea_pkg::WORD_W-1:0] push_data = sample_free ? last_r : norm_word;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ti_sync_r <= 2'h0;
			ti_prev_r <= 1'b0;
			mono_r <= sea_pkg::CNT_RST;
			upd_r <= sea_pkg::CNT_RST;
			skip_r <= 8'h00;
		end else begin
			ti_sync_r <= {ti_sync_r[0], iso_ti_i};
			ti_prev_r <= ti_sync_r[1];
			mono_r <= (mono_end || link_busy) ? sea_pkg::CNT_RST : mono_r + sea_pkg::CNT_W'(1);
			upd_r <= upd_end ? sea_pkg::CNT_RST : upd_r + sea_pkg::CNT_W'(1);
			if (run_iso && ti_rise) begin
				skip_r <= (skip_r == 8'h00) ? iso_skip_i : skip_r - 8'h01;
			end else if (!run_iso) begin
				skip_r <= 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			valid_r <= 1'b0;
			last_r <= sea_pkg::POS_RST;
			life_r <= sea_pkg::LIFE_RST;
		end else begin
			if (!enable_i || !type_good) begin
				valid_r <= 1'b0;
			end else if (link_done) begin
				valid_r <= 1'b1;
				last_r <= norm_word;
			end
			if (push_word && fifo_in_ready) begin
				life_r <= life_r + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fb_value_o <= sea_pkg::POS_RST;
			fb_life_o <= sea_pkg::LIFE_RST;
		end else if (fifo_out_valid && fb_ready_i) begin
			fb_value_o <= fifo_out_data;
			fb_life_o <= life_r;
		end
	end

	// ----------------------------------------
	// Link master and buffer
	// ----------------------------------------
	sea_link u_link (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.start_i(frame_start),
		.nbits_i(nbits),
		.data_i(enc_data_i),
		.sclk_o(enc_clk_o),
		.busy_o(link_busy),
		.done_o(link_done),
		.word_o(link_word)
	);

	sea_fifo #(
		.WIDTH(sea_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(push_word),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fb_ready_i),
		.out_data_o(fifo_out_data)
	);

	assign fb_strobe_o = fifo_out_valid && fb_ready_i;
	assign fifo_full_o = !fifo_in_ready;
	// ready while enabled, width type legal and value valid and, in iso mode, bus cycle ok
	assign fb_ready_op_o = enable_i && type_good && valid_r && (!iso_mode_i || iso_ok_i);
	// comparator and latch absent in fast variant
	assign cmp_latch_avail_o = !fast_mode_i;
endmodule

// ==== sea_acq_assertions.sv ====
// Port-level checks of the acquisition top
`timescale 1ns/1ps
module sea_acq_assertions (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic iso_mode_i,
	input wire logic iso_ti_i,
	input wire logic fast_mode_i,
	input wire logic [2:0] enc_type_i,
	input wire logic enc_clk_o,
	input wire logic [sea_pkg::WORD_W-1:0] fb_value_o,
	input wire logic fb_strobe_o,
	input wire logic fb_ready_i,
	input wire logic fb_ready_op_o,
	input wire logic cmp_latch_avail_o,
	input wire logic fifo_full_o
);
	// ----
	// Phase and instant counters
	// ----
	logic [15:0] lo_r, hi_r;
	logic [7:0] ti_r;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lo_r <= 16'h0000;
			hi_r <= 16'h0000;
			ti_r <= 8'hFF;
		end else begin
			lo_r <= enc_clk_o ? 16'h0000 : lo_r + 16'h0001;
			hi_r <= enc_clk_o ? hi_r + {15'h0000, hi_r != 16'hFFFF} : 16'h0000;
			ti_r <= $rose(iso_ti_i) ? 8'h00 : ti_r + {7'h00, ti_r != 8'hFF};
		end
	end
	// ----
	// Properties
	// ----
	a_low_phase: assert property (
		$rose(enc_clk_o) |-> lo_r == 16'h00C8)
		else $error("link clock low phase length wrong");
	a_start_legal: assert property (
		$fell(enc_clk_o) && hi_r > 16'h00C8 |-> enable_i && enc_type_i <= sea_pkg::ENC_25)
		else $error("frame start while disabled or illegal width");
	a_iso_start: assert property (
		$fell(enc_clk_o) && hi_r > 16'h00C8 && $past(iso_mode_i, 201) |-> ti_r <= 8'hFA)
		else $error("isochronous frame without input instant");
	a_variant_avail: assert property (
		cmp_latch_avail_o == !fast_mode_i)
		else $error("comparator availability wrong");
	a_value_hold: assert property (
		!fb_strobe_o |=> $stable(fb_value_o))
		else $error("feedback value changed without strobe");
	a_strobe_ready: assert property (
		fb_strobe_o |-> fb_ready_i)
		else $error("strobe without consumer ready");
	a_full_drain: assert property (
		fifo_full_o && fb_ready_i |-> fb_strobe_o)
		else $error("full buffer not drained");
	a_ready_op: assert property (
		fb_ready_op_o |-> enable_i && enc_type_i <= sea_pkg::ENC_25)
		else $error("ready while not operational");
endmodule
bind sea_acq sea_acq_assertions u_sea_acq_assertions (.core_clk_i, .nrst_i, .enable_i, .iso_mode_i, .iso_ti_i,
	.fast_mode_i, .enc_type_i, .enc_clk_o, .fb_value_o, .fb_strobe_o, .fb_ready_i, .fb_ready_op_o,
	.cmp_latch_avail_o, .fifo_full_o);

// ==== sea_enc_model.sv ====
// Behavioural absolute encoder on the serial link
`timescale 1ns/1ps
module sea_enc_model (
	input wire logic clk_i,
	input wire logic [sea_pkg::WORD_W-1:0] word_i,
	input wire logic [sea_pkg::BITS_W-1:0] nbits_i,
	output logic data_o
);
	int idx = 0;
	realtime t_rise = 0;
	initial data_o = 1'h1;
	always @(negedge clk_i) begin
		if (idx >= nbits_i || $realtime - t_rise > 1500)
			idx = 0;
		data_o = word_i[nbits_i - 5'h01 - 5'(idx)];
		idx++;
	end
	// Released line shows inverse level
	always @(posedge clk_i) begin
		t_rise = $realtime;
		if (idx >= nbits_i)
			data_o <= #100 ~data_o;
	end
endmodule

// ==== sea_fifo.sv ====
// Parameterised valid/ready FIFO for acquired words
`timescale 1ns/1ps
module sea_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire logic push = in_valid_i && in_ready_o;
	wire logic pop = out_valid_o && out_ready_i;

	assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem[rd_r];

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==== sea_link.sv ====
// Serial link master: clocks one frame and shifts in the encoder word
`timescale 1ns/1ps
module sea_link #(
	parameter int HALF_CYC = sea_pkg::LINK_HALF_CYC
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [sea_pkg::BITS_W-1:0] nbits_i,
	input wire logic data_i,
	output logic sclk_o,
	output logic busy_o,
	output logic done_o,
	output logic [sea_pkg::WORD_W-1:0] word_o
);
	logic [1:0] sync_r;
	logic [15:0] half_r;
	logic [sea_pkg::BITS_W:0] edge_r;
	logic [sea_pkg::WORD_W-1:0] sh_r;
	logic run_r;
	wire logic tick = half_r == 16'(HALF_CYC - 1);
	// Twice the bit count; the tick at this count ends the frame after one idle half period
	wire logic [sea_pkg::BITS_W:0] last_edge = {nbits_i, 1'b0};

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_r <= 2'h0;
			half_r <= sea_pkg::HALF_RST;
			edge_r <= '0;
			sh_r <= sea_pkg::POS_RST;
			run_r <= 1'b0;
			sclk_o <= 1'b1;
			done_o <= 1'b0;
			word_o <= sea_pkg::POS_RST;
		end else begin
			sync_r <= {sync_r[0], data_i};
			done_o <= 1'b0;
			if (!run_r && start_i) begin
				run_r <= 1'b1;
				half_r <= sea_pkg::HALF_RST;
				edge_r <= '0;
				sh_r <= sea_pkg::POS_RST;
			end else if (run_r) begin
				half_r <= tick ? sea_pkg::HALF_RST : half_r + 16'h0001;
				if (tick) begin
					edge_r <= edge_r + (sea_pkg::BITS_W+1)'(1);
					// one pulse per bit, MSB first
					if (edge_r < last_edge) begin
						sclk_o <= edge_r[0];
						if (edge_r[0]) begin
							sh_r <= {sh_r[sea_pkg::WORD_W-2:0], sync_r[1]};
						end
					end else begin
						sclk_o <= 1'b1;
						run_r <= 1'b0;
						done_o <= 1'b1;
						word_o <= sh_r;
					end
				end
			end
		end
	end
	assign busy_o = run_r;
endmodule

// ==== sea_pkg.sv ====
// Shared constants and types for the encoder value acquisition block
package sea_pkg;
	// ----------------------------------------
	// Acquisition and code settings
	// ----------------------------------------
	localparam logic DET_FREE = 1'b0;
	localparam logic DET_SYNC = 1'b1;
	localparam logic CODE_BINARY = 1'b0;
	localparam logic CODE_GRAY = 1'b1;
	// ----------------------------------------
	// Frame width type codes
	// ----------------------------------------
	localparam logic [2:0] ENC_13 = 3'h0;
	localparam logic [2:0] ENC_14 = 3'h1;
	localparam logic [2:0] ENC_16 = 3'h2;
	localparam logic [2:0] ENC_21 = 3'h3;
	localparam logic [2:0] ENC_24 = 3'h4;
	localparam logic [2:0] ENC_25 = 3'h5;
	localparam int WORD_W = 25;
	localparam int CNT_W = 24;
	localparam int BITS_W = 5;
	localparam int SHIFT_W = 5;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LINK_HALF_NS = 1000;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MONOFLOP_US = 64;
	localparam int MONOFLOP_CYC = (MONOFLOP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int UPDATE_US = 500;
	localparam int UPDATE_CYC = (UPDATE_US * 1000000) / CLK_PERIOD_PS;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [WORD_W-1:0] POS_RST = 25'h0000000;
	localparam logic [BITS_W-1:0] BITS_RST = 5'h00;
	localparam logic [7:0] LIFE_RST = 8'h00;
	localparam logic [15:0] HALF_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

	// Frame width in bits for a type code
	function automatic logic [BITS_W-1:0] frame_bits(input logic [2:0] t);
		logic [BITS_W-1:0] b;
		b = 5'h0D;
		case (t)
			ENC_14: b = 5'h0E;
			ENC_16: b = 5'h10;
			ENC_21: b = 5'h15;
			ENC_24: b = 5'h18;
			ENC_25: b = 5'h19;
			default: b = 5'h0D;
		endcase
		return b;
	endfunction

	// Legal width codes
	function automatic logic type_ok(input logic [2:0] t);
		return t <= ENC_25;
	endfunction
endpackage

// ==== tb_sea_acq.sv ====
// Self-checking bench for the acquisition top
`timescale 1ns/1ps
module tb_sea_acq;
	logic clk, nrst, en, iso, iso_ok, ti, det, gray, norm, fast, fbr, sda, sck, fbs, rdy, cla, full, got;
	logic [2:0] ety;
	logic [4:0] trl, nb;
	logic [24:0] stp, wrd, fbv;
	logic [7:0] skp, lif;
	int failures = 0, compares = 0, cnt;
	int wid [6] = '{13, 14, 16, 21, 24, 25};
	localparam logic [24:0] W = 25'h1B5A3C7;
	localparam logic [24:0] B = 25'h1ABCDE5;
	sea_acq #(.MONOFLOP_CYCLES(50), .UPDATE_CYCLES(400), .FIFO_DEPTH(32)) u_sea_acq (
		.core_clk_i(clk), .nrst_i(nrst), .enable_i(en), .iso_mode_i(iso), .iso_ok_i(iso_ok), .iso_ti_i(ti),
		.iso_skip_i(skp), .detect_i(det), .code_gray_i(gray), .norm_on_i(norm), .fast_mode_i(fast),
		.enc_type_i(ety), .trail_bits_i(trl), .total_steps_i(stp), .enc_data_i(sda), .enc_clk_o(sck),
		.fb_value_o(fbv), .fb_strobe_o(fbs), .fb_ready_i(fbr), .fb_life_o(lif), .fb_ready_op_o(rdy),
		.cmp_latch_avail_o(cla), .fifo_full_o(full));
	sea_enc_model u_sea_enc_model (.clk_i(sck), .word_i(wrd), .nbits_i(nb), .data_o(sda));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [24:0] s, input logic [24:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wstr(input int lim);
		got = 1'h0;
		for (int i = 0; i < lim && !got; i++) begin
			@(negedge clk);
			got = (fbs === 1'h1);
		end
	endtask
	task automatic pulse_ti();
		ti = 1'h1;
		repeat (4) @(negedge clk);
		ti = 1'h0;
	endtask
	task automatic run(input logic [2:0] t, input logic g, input logic [4:0] tr, input logic [24:0] w, e);
		{ety, gray, norm, trl, wrd} = {t, g, g, tr, w};
		stp = g ? 25'h0000200 : 25'h0000000;
		nb = 5'(wid[t]);
		pulse_ti();
		wstr(12000);
		chk("frame strobe", got, 1);
		if (!got)
			end_sim();
		@(negedge clk);
		chk("feedback value", fbv, e);
		chk("ready flag", rdy, 1);
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		{nrst, en, iso, iso_ok, fbr, ti, det, gray, norm, fast} = 10'h1E0;
		{ety, trl, stp, wrd, nb, skp} = {3'h0, 5'h00, 25'h0000000, W, 5'h0D, 8'h00};
		repeat (4) @(negedge clk);
		nrst = 1'h1;
		chk("variant std", cla, 1);
		fast = 1'h1;
		@(negedge clk);
		chk("variant fast", cla, 0);
		fast = 1'h0;
		cnt = 0;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			cnt += (sck !== 1'h1);
		end
		chk("iso link idle", 25'(cnt), 0);
		chk("no value yet", rdy, 0);
		for (int i = 0; i < 6; i++)
			run(3'(i), 1'h0, 5'h00, W, W & ((25'h1 << wid[i]) - 25'h1));
		skp = 8'h01;
		run(sea_pkg::ENC_25, 1'h1, 5'h04, B ^ (B >> 1), 25'h00000DE);
		{gray, norm, ety, nb, wrd, skp} = {2'h0, 3'h0, 5'h0D, W, 8'h00};
		pulse_ti();
		wstr(6000);
		chk("skipped instant", got, 0);
		iso_ok = 1'h0;
		pulse_ti();
		wstr(6000);
		chk("iso fail update", got, 0);
		{iso_ok, ety} = {1'h1, 3'h6};
		@(negedge clk);
		chk("illegal width", rdy, 0);
		{iso, det, ety} = {2'h1, 3'h0};
		wstr(7000);
		chk("sync strobe", got, 1);
		@(negedge clk);
		chk("sync value", fbv, W & 25'h1FFF);
		{det, fbr} = 2'h0;
		cnt = 0;
		while (full !== 1'h1 && cnt < 20000) begin
			@(negedge clk);
			cnt++;
		end
		chk("fifo full", full, 1);
		{iso, iso_ok, fbr} = 3'h5;
		cnt = 0;
		for (int i = 0; i < 40; i++) begin
			#1 cnt += (fbs === 1'h1);
			@(negedge clk);
		end
		chk("drain count", 25'(cnt), 25'h0000020);
		chk("latest value", fbv, W & 25'h1FFF);
		chk("life count", 25'(lif), 25'h0000028);
		end_sim();
	end
endmodule
